//--- verification/supmon_chk.sv
/* assertions on the host sequencer pins.
 assumes binding to the top module, SETTLE_CYC as set there. */
`timescale 1ns/10ps
`default_nettype none
module supmon_chk #(parameter int SETTLE_CYC = 4)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic o_unlock_wr,
	input wire logic o_unlock_val,
	input wire logic o_ctrl_wr,
	input wire logic [7:0] o_ctrl_val,
	input wire logic o_elink_en,
	input wire logic o_option_zero_rst_dis
);
	logic stop_q;
	int cnt_q;
	logic cfg_wr;
	assign cfg_wr = i_psel && i_pwrite && i_paddr == 12'h000;
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			stop_q <= 1'b1;
			cnt_q <= 0;
		end
		else if (o_ctrl_wr)
		begin
			stop_q <= !o_ctrl_val[7];
			cnt_q <= 0;
		end
		else if (cnt_q < 100)
			cnt_q <= cnt_q + 1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_lock;
		o_unlock_wr && !o_unlock_val;
	endsequence
	sequence s_on;
		o_ctrl_wr && o_ctrl_val[7];
	endsequence
	property p_unl;
		o_ctrl_wr |-> $past(o_unlock_wr && o_unlock_val);
	endproperty
	a_unl: assert property (p_unl) else $error("control write while locked");
	property p_lvl;
		s_on |-> o_ctrl_val[4:0] >= 5'h0E;
	endproperty
	a_lvl: assert property (p_lvl) else $error("bad level code");
	property p_settle;
		o_unlock_wr && !o_unlock_val && !stop_q |-> cnt_q >= SETTLE_CYC - 1;
	endproperty
	a_settle: assert property (p_settle) else $error("relock before settle");
	property p_relock;
		s_on |-> ##[1:12] s_lock;
	endproperty
	a_relock: assert property (p_relock) else $error("no relock after start");
	property p_stop;
		o_ctrl_wr && !o_ctrl_val[7] |-> ##[1:12] s_lock;
	endproperty
	a_stop: assert property (p_stop) else $error("no relock after stop");
	property p_link_on;
		$rose(o_elink_en) |-> !stop_q && $past(o_unlock_wr && !o_unlock_val);
	endproperty
	a_link_on: assert property (p_link_on) else $error("link before enable");
	property p_link_off;
		$fell(o_elink_en) |-> stop_q;
	endproperty
	a_link_off: assert property (p_link_off) else $error("unlink before stop");
	property p_opt;
		$changed(o_option_zero_rst_dis) |-> $past(cfg_wr) || $past(cfg_wr, 2);
	endproperty
	a_opt: assert property (p_opt) else $error("option bit moved alone");
endmodule
`default_nettype wire

//--- verification/supmon_dev_model.sv
/* model of the second supply monitor.
 assumes host pin strobes and a supply-low level from the bench. */
`timescale 1ns/10ps
`default_nettype none
module supmon_dev_model #(parameter int SETTLE = 4)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_unlock_wr,
	input wire logic i_unlock_val,
	input wire logic i_ctrl_wr,
	input wire logic [7:0] i_ctrl_val,
	input wire logic i_vlow,
	output logic o_irq_req,
	output logic o_int_reset,
	output logic o_monitor_ok,
	output logic o_irq_nmi
);
	logic unl_q, low_q, on_q, on;
	logic [7:0] ctrl_q;
	int cnt_q;
	assign on = ctrl_q[7] && cnt_q >= SETTLE && !unl_q;
	assign o_int_reset = on && ctrl_q[6] && i_vlow;
	assign o_monitor_ok = !(ctrl_q[7] && i_vlow);
	assign o_irq_nmi = o_irq_req && !ctrl_q[5];
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			unl_q <= 1'b0;
			ctrl_q <= 8'h00;
			cnt_q <= 0;
			{low_q, on_q, o_irq_req} <= 3'h0;
		end
		else
		begin
			if (i_unlock_wr)
				unl_q <= i_unlock_val;
			if (i_ctrl_wr && unl_q)
				ctrl_q <= i_ctrl_val;
			cnt_q <= (i_ctrl_wr && unl_q) ? 0 : (cnt_q < SETTLE ? cnt_q + 1 : cnt_q);
			low_q <= i_vlow;
			on_q <= on;
			o_irq_req <= on && !ctrl_q[6] && (i_vlow != low_q || (!on_q && i_vlow));
		end
	end
endmodule
`default_nettype wire

//--- verification/tb_supply_monitor_irq_reset_ctrl.sv
/* bench: apb master, device model, checker bind.
 assumes a 10 MHz clock and SETTLE_CYC of 4. */
`timescale 1ns/10ps
`default_nettype none
module tb_supply_monitor_irq_reset_ctrl
	import supmon_host_pkg::*;
;
	logic i_clk = 0, i_rst = 1, ps = 0, pe = 0, pw = 0, vlow = 0;
	logic [11:0] pa = 0;
	logic [31:0] pd = 0, prd, rd;
	logic rdy, irq, uw, uv, cw, elk, m0, rq, rs, ok, dc, nmi, tseen;
	int n_cw = 0, n_dc = 0;
	logic [7:0] cv, seen;
	logic [8:0] cfg;
	int bad_count = 0, n_tests = 0, seed = 32'hEC58, i;
	always #50 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		if (cw === 1'b1)
		begin
			seen <= cv;
			n_cw <= n_cw + 1;
		end
		if (dc === 1'b1)
			n_dc <= n_dc + 1;
		if (rq === 1'b1)
			tseen <= nmi;
	end
	supply_monitor_irq_reset_ctrl #(.SETTLE_CYC(4)) u_supply_monitor_irq_reset_ctrl (.i_clk(i_clk),
		.i_rst(i_rst), .i_psel(ps), .i_penable(pe), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd),
		.o_prdata(prd), .o_pready(rdy), .o_pslverr(), .o_irq(irq), .o_unlock_wr(uw),
		.o_unlock_val(uv), .o_ctrl_wr(cw), .o_ctrl_val(cv), .o_det_clr(dc), .o_elink_en(elk),
		.o_option_zero_rst_dis(m0), .i_irq_req(rq), .i_int_reset(rs), .i_monitor_ok(ok));
	supmon_dev_model #(.SETTLE(4)) u_supmon_dev_model (.i_clk(i_clk), .i_rst(i_rst),
		.i_unlock_wr(uw), .i_unlock_val(uv), .i_ctrl_wr(cw), .i_ctrl_val(cv), .i_vlow(vlow),
		.o_irq_req(rq), .o_int_reset(rs), .o_monitor_ok(ok), .o_irq_nmi(nmi));
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		n_tests++;
		if (s !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, s);
			bad_count++;
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		{ps, pe, pw, pa, pd} <= {1'b1, 1'b0, w, a, d};
		@(posedge i_clk);
		pe <= 1'b1;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (rdy !== 1'b1 && n < 20);
		rd = prd;
		{ps, pe} <= 2'b00;
		if (n >= 20)
		begin
			bad_count++;
			conclude();
		end
	endtask
	task automatic idle;
		int n;
		n = 0;
		do
		begin
			apb(0, OFS_STATUS, 0);
			n++;
		end
		while (rd[5] !== 1'b0 && n < 40);
		if (n >= 40)
		begin
			bad_count++;
			conclude();
		end
	endtask
	initial
	begin
		repeat (20000) @(posedge i_clk);
		bad_count++;
		conclude();
	end
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		apb(0, OFS_CONFIG, 0);
		chk(rd, {23'h0, CFG_RESET}, "config");
		chk(m0, 1, "m0 dis");
		apb(0, 12'h0FC, 0);
		chk(rd, 0, "unmapped");
		apb(1, OFS_IRQ_MASK, 32'h0000_000F);
		for (i = 0; i < 4; i++)
		begin
			vlow <= i[1];
			cfg = {2'b11, i[0], 1'($random(seed)), LEVEL_MIN + 5'($unsigned($random(seed)) % 18)};
			apb(1, OFS_CONFIG, {23'h0, cfg});
			apb(1, OFS_COMMAND, 32'h0000_0001);
			idle();
			repeat (6) @(posedge i_clk);
			chk(seen, {1'b1, cfg[6:0]}, "ctrl");
			chk(m0, 0, "m0 dis");
			chk(elk, !cfg[6], "link on");
			chk(irq, 1, "irq");
			apb(0, OFS_STATUS, 0);
			chk(rd[2], cfg[6] & vlow, "int reset");
			apb(0, OFS_IRQ_STAT, 0);
			chk(rd[2], !cfg[6] & vlow, "irq req");
			apb(1, OFS_IRQ_STAT, 32'h0000_0004);
			vlow <= !vlow;
			repeat (8) @(posedge i_clk);
			apb(0, OFS_IRQ_STAT, 0);
			chk(rd[2], !cfg[6], "crossing");
			if (!cfg[6])
				chk(tseen, !cfg[5], "irq type");
			apb(1, OFS_COMMAND, 32'h0000_0002);
			idle();
			chk(seen[7], 0, "ctrl off");
			chk(elk, 0, "link off");
			apb(1, OFS_IRQ_STAT, 32'h0000_000F);
			@(negedge i_clk);
			chk(irq, 0, "irq clear");
		end
		apb(1, OFS_COMMAND, 32'h0000_0004);
		repeat (2) @(posedge i_clk);
		chk(n_dc, 1, "det clr");
		apb(1, OFS_CONFIG, 32'h0000_000D);
		apb(1, OFS_COMMAND, 32'h0000_0001);
		idle();
		chk(n_cw, 8, "refused");
		apb(0, OFS_IRQ_STAT, 0);
		chk(rd[1], 1, "bad cfg");
		chk(irq, 1, "irq bad");
		apb(1, OFS_IRQ_MASK, 0);
		@(negedge i_clk);
		chk(irq, 0, "masked");
		conclude();
	end
endmodule
bind supply_monitor_irq_reset_ctrl supmon_chk #(.SETTLE_CYC(SETTLE_CYC)) u_supmon_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_unlock_wr(o_unlock_wr), .o_unlock_val(o_unlock_val), .o_ctrl_wr(o_ctrl_wr),
	.o_ctrl_val(o_ctrl_val), .o_elink_en(o_elink_en),
	.o_option_zero_rst_dis(o_option_zero_rst_dis));
`default_nettype wire

//--- verilog/supmon_host_pkg.sv
/*
 package for the supply monitor host sequencer: own register map, device field layout,
 sequencer timing. assumes a 10 MHz system clock.
*/
// Summary of operation
// - monitor zero resets only when its option word reset-disable bit is zero
// - host sets the write unlock bit before any control register change
// - interrupt setup writes mode zero with level and enable
// - interrupt setup also writes the chosen interrupt type select
// - reset setup writes mode one with level and enable
// - after enable the host waits the settle time before continuing
// - after settle the host clears the write unlock bit to relock
// - stop: unlock, write enable zero, then relock
// - event link is enabled only after the monitor is enabled
// - event link is disabled only after the monitor is stopped
// - host only writes detection level codes 0x0E through 0x1F
package supmon_host_pkg;
	// ****************************
	// own apb registers
	// ****************************
	localparam logic [11:0] OFS_CONFIG = 12'h000;
	localparam logic [11:0] OFS_COMMAND = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
	// config fields
	localparam int CFG_LEVEL_LSB = 0;
	localparam int CFG_TYPE_BIT = 5;
	localparam int CFG_MODE_BIT = 6;
	localparam int CFG_ELINK_BIT = 7;
	localparam int CFG_M0RST_BIT = 8;
	localparam logic [8:0] CFG_RESET = 9'h00E;
	// command bits
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int CMD_CLRDET_BIT = 2;
	// irq status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_BADCFG_BIT = 1;
	localparam int IRQ_REQ_BIT = 2;
	localparam int IRQ_RST_BIT = 3;
	// ****************************
	// device control field layout
	// ****************************
	localparam int DEV_TYPE_BIT = 5;
	localparam int DEV_MODE_BIT = 6;
	localparam int DEV_EN_BIT = 7;
	localparam logic [4:0] LEVEL_MIN = 5'h0E;
	localparam logic [4:0] LEVEL_MAX = 5'h1F;
	// ****************************
	// timing
	// ****************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int SETTLE_TIME_NS = 300000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
endpackage

//--- verilog/supply_monitor_irq_reset_ctrl.sv
/*
 host sequencer driving the second supply monitor's control pins.
 apb slave for orders and status; device register writes are single-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_irq_reset_ctrl
	import supmon_host_pkg::*;
#(
	parameter int SETTLE_CYC = SETTLE_CYCLES
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	output logic o_unlock_wr,
	output logic o_unlock_val,
	output logic o_ctrl_wr,
	output logic [7:0] o_ctrl_val,
	output logic o_det_clr,
	output logic o_elink_en,
	output logic o_option_zero_rst_dis,
	input wire logic i_irq_req,
	input wire logic i_int_reset,
	input wire logic i_monitor_ok
);
	typedef enum {S_IDLE, S_UNLOCK, S_WRITE, S_SETTLE, S_LOCK, S_ELINK,
		S_SUNLINK, S_SUNLOCK, S_SDIS, S_SLOCK} seq_e;

	seq_e state_q;
	logic [8:0] cfg_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [CNT_W-1:0] cnt_q;
	logic running_q;
	logic req_s1_q, req_s2_q, req_s3_q;
	logic rst_s1_q, rst_s2_q;
	logic ok_s1_q, ok_s2_q;
	logic wr, rd;
	logic start_cmd, stop_cmd, bad_level;
	logic [3:0] ev;

	// ****************************
	// apb slave
	// ****************************
	assign wr = i_psel && i_penable && i_pwrite;
	assign rd = i_psel && !i_pwrite;
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;
	assign start_cmd = wr && (i_paddr == OFS_COMMAND) && i_pwdata[CMD_START_BIT];
	assign stop_cmd = wr && (i_paddr == OFS_COMMAND) && i_pwdata[CMD_STOP_BIT];
	assign bad_level = (cfg_q[4:0] < LEVEL_MIN) || (cfg_q[4:0] > LEVEL_MAX);

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			cfg_q <= CFG_RESET;
		else if (wr && (i_paddr == OFS_CONFIG) && state_q == S_IDLE)
			cfg_q <= i_pwdata[8:0];
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			irq_mask_q <= 4'h0;
		else if (wr && (i_paddr == OFS_IRQ_MASK))
			irq_mask_q <= i_pwdata[3:0];
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_prdata <= 32'h0000_0000;
		else if (rd && !i_penable)
		begin
			unique case (i_paddr)
				OFS_CONFIG: o_prdata <= {23'h0, cfg_q};
				OFS_STATUS: o_prdata <= {26'h0, (state_q != S_IDLE), running_q,
					ok_s2_q, rst_s2_q, req_s2_q, o_elink_en};
				OFS_IRQ_STAT: o_prdata <= {28'h0, irq_stat_q};
				OFS_IRQ_MASK: o_prdata <= {28'h0, irq_mask_q};
				default: o_prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************
	// pin synchronisers
	// ****************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
			ok_s1_q <= 1'b0;
			ok_s2_q <= 1'b0;
		end
		else
		begin
			req_s1_q <= i_irq_req;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			rst_s1_q <= i_int_reset;
			rst_s2_q <= rst_s1_q;
			ok_s1_q <= i_monitor_ok;
			ok_s2_q <= ok_s1_q;
		end
	end

	// ****************************
	// sequencer
	// ****************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_q <= S_IDLE;
			cnt_q <= '0;
			running_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				S_IDLE:
				begin
					if (start_cmd && !bad_level && !running_q)
						state_q <= S_UNLOCK;
					else if (stop_cmd && running_q)
						state_q <= o_elink_en ? S_SUNLINK : S_SUNLOCK;
				end
				S_UNLOCK: state_q <= S_WRITE;
				S_WRITE:
				begin
					cnt_q <= CNT_W'(SETTLE_CYC);
					state_q <= S_SETTLE;
				end
				S_SETTLE:
				begin
					if (cnt_q <= CNT_W'(1))
						state_q <= S_LOCK;
					else
						cnt_q <= cnt_q - CNT_W'(1);
				end
				S_LOCK:
				begin
					running_q <= 1'b1;
					state_q <= cfg_q[CFG_ELINK_BIT] && !cfg_q[CFG_MODE_BIT] ? S_ELINK : S_IDLE;
				end
				S_ELINK: state_q <= S_IDLE;
				S_SUNLINK: state_q <= S_SUNLOCK;
				S_SUNLOCK: state_q <= S_SDIS;
				S_SDIS: state_q <= S_SLOCK;
				S_SLOCK:
				begin
					running_q <= 1'b0;
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// ****************************
	// device pin drive
	// ****************************
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_unlock_wr <= 1'b0;
			o_unlock_val <= 1'b0;
			o_ctrl_wr <= 1'b0;
			o_ctrl_val <= 8'h00;
		end
		else
		begin
			o_unlock_wr <= 1'b0;
			o_ctrl_wr <= 1'b0;
			if (state_q == S_UNLOCK || state_q == S_SUNLOCK)
			begin
				o_unlock_wr <= 1'b1;
				o_unlock_val <= 1'b1;
			end
			if (state_q == S_LOCK || state_q == S_SLOCK)
			begin
				o_unlock_wr <= 1'b1;
				o_unlock_val <= 1'b0;
			end
			if (state_q == S_WRITE)
			begin
				o_ctrl_wr <= 1'b1;
				o_ctrl_val[4:0] <= cfg_q[4:0];
				o_ctrl_val[DEV_TYPE_BIT] <= cfg_q[CFG_TYPE_BIT];
				o_ctrl_val[DEV_MODE_BIT] <= cfg_q[CFG_MODE_BIT];
				o_ctrl_val[DEV_EN_BIT] <= 1'b1;
			end
			if (state_q == S_SDIS)
			begin
				o_ctrl_wr <= 1'b1;
				o_ctrl_val[DEV_EN_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_elink_en <= 1'b0;
		else if (state_q == S_ELINK)
			o_elink_en <= 1'b1;
		else if (state_q == S_SUNLINK && !running_q)
			o_elink_en <= 1'b0;
		else if (state_q == S_SLOCK)
			o_elink_en <= 1'b0;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_option_zero_rst_dis <= 1'b1;
		else
			o_option_zero_rst_dis <= !cfg_q[CFG_M0RST_BIT];
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			o_det_clr <= 1'b0;
		else
			o_det_clr <= wr && (i_paddr == OFS_COMMAND) && i_pwdata[CMD_CLRDET_BIT];
	end

	// ****************************
	// interrupts
	// ****************************
	assign ev[IRQ_DONE_BIT] = (state_q == S_LOCK) || (state_q == S_SLOCK);
	assign ev[IRQ_BADCFG_BIT] = start_cmd && bad_level && state_q == S_IDLE;
	assign ev[IRQ_REQ_BIT] = req_s2_q && !req_s3_q;
	assign ev[IRQ_RST_BIT] = rst_s2_q;

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			irq_stat_q <= 4'h0;
		else if (wr && (i_paddr == OFS_IRQ_STAT))
			irq_stat_q <= (irq_stat_q & ~i_pwdata[3:0]) | ev;
		else
			irq_stat_q <= irq_stat_q | ev;
	end

	assign o_irq = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire
